// ==== inc/mfsc_defs.svh ====
/*
 * Offsets, field positions, reset value and codes of the modem format and
 * sync configuration block. Included by the package and the design file.
 */
`ifndef MFSC_DEFS_SVH
`define MFSC_DEFS_SVH

`define MFSC_CFG_ADDR      6'h12
`define MFSC_CFG_RESET     8'h02
`define MFSC_BIT_DC_BYP    7
`define MFSC_FLD_MOD_HI    6
`define MFSC_FLD_MOD_LO    4
`define MFSC_BIT_BIPHASE   3
`define MFSC_FLD_SYNC_HI   2
`define MFSC_FLD_SYNC_LO   0

`define MFSC_MOD_2FSK      3'h0
`define MFSC_MOD_GFSK      3'h1
`define MFSC_MOD_OOK       3'h3
`define MFSC_MOD_4FSK      3'h4

`define MFSC_LEN16         6'h10
`define MFSC_LEN32         6'h20
`define MFSC_MISS16_MAX    6'h01
`define MFSC_MISS32_MAX    6'h02
`define MFSC_DC_SHIFT      5

`endif

// ==== inc/mfsc_pkg.sv ====
/*
 * Types of the modem format and sync configuration block.
 * Assumes mfsc_defs.svh is on the include path.
 */
`include "mfsc_defs.svh"

package mfsc_pkg;

   typedef enum logic [1:0] {
      MFSC_HUNT = 2'b00,
      MFSC_RECV = 2'b01
   } mfsc_state_t;

   typedef struct packed {
      logic       dc_block_bypass;
      logic [2:0] modulation_select;
      logic       biphase_en;
      logic [2:0] sync_mode;
   } mfsc_cfg_t;

endpackage

// ==== src/mfsc_top.sv ====
/*
 * Modem format / sync qualifier configuration register with the datapath
 * it steers: DC blocking filter, biphase coder and sync word qualifier.
 * Assumes one clock, synchronous inputs and a byte-wide register port.
 */
`timescale 1ns/10ps
`include "mfsc_defs.svh"

module mfsc_top (
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   input  wire logic [5:0]       addr_i,
   input  wire logic             wr_en_i,
   input  wire logic [7:0]       wdata_i,
   output logic      [7:0]       rdata_o,
   output mfsc_pkg::mfsc_cfg_t   cfg_o,
   input  wire logic             serial_mode_i,
   input  wire logic signed [7:0] sample_i,
   input  wire logic             sample_valid_i,
   output logic signed [8:0]     demod_sample_o,
   output logic                  demod_valid_o,
   input  wire logic             tx_bit_i,
   input  wire logic             tx_bit_valid_i,
   output logic                  tx_chip_o,
   output logic                  tx_chip_valid_o,
   input  wire logic             rx_chip_i,
   input  wire logic             rx_chip_valid_i,
   input  wire logic [15:0]      sync_word_i,
   input  wire logic             carrier_sense_i,
   input  wire logic             rx_done_i,
   output logic                  pkt_start_o,
   output logic                  rx_active_o,
   output logic                  rx_data_o,
   output logic                  rx_data_valid_o
);
   import mfsc_pkg::*;

   mfsc_cfg_t          cfg_reg;
   mfsc_state_t        state_reg;
   logic signed [15:0] avg_reg;
   logic               chip2_reg;
   logic               chip2_val_reg;
   logic               rx_phase_reg;
   logic               rx_first_reg;
   logic [31:0]        shift_reg;
   logic [5:0]         seen_reg;
   logic               biphase_eff;
   logic               bit_valid;
   logic               bit_val;
   logic [5:0]         miss16;
   logic [5:0]         miss32;
   logic               qual_c;
   logic               mod_ok;

   function automatic logic [5:0] ones32(input logic [31:0] v);
      logic [5:0] n;
      n = 6'h00;
      for (int i = 0; i < 32; i++) begin
         n = n + {5'h00, v[i]};
      end
      return n;
   endfunction

   assign cfg_o = cfg_reg;

   // Register write; a reserved modulation code leaves the field unchanged
   assign mod_ok = (wdata_i[6:4] == `MFSC_MOD_2FSK) || (wdata_i[6:4] == `MFSC_MOD_GFSK) ||
                   (wdata_i[6:4] == `MFSC_MOD_OOK) || (wdata_i[6:4] == `MFSC_MOD_4FSK);

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_reg <= `MFSC_CFG_RESET;
      end else if (wr_en_i && addr_i == `MFSC_CFG_ADDR) begin
         cfg_reg.dc_block_bypass <= wdata_i[`MFSC_BIT_DC_BYP];
         if (mod_ok) begin
            cfg_reg.modulation_select <= wdata_i[`MFSC_FLD_MOD_HI:`MFSC_FLD_MOD_LO];
         end
         cfg_reg.biphase_en <= wdata_i[`MFSC_BIT_BIPHASE];
         cfg_reg.sync_mode  <= wdata_i[`MFSC_FLD_SYNC_HI:`MFSC_FLD_SYNC_LO];
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (addr_i == `MFSC_CFG_ADDR) begin
         rdata_o <= cfg_reg;
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // DC blocking filter, bypassed by the control bit
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         avg_reg        <= 16'h0000;
         demod_sample_o <= 9'h000;
         demod_valid_o  <= 1'b0;
      end else begin
         demod_valid_o <= sample_valid_i;
         if (sample_valid_i) begin
            if (cfg_reg.dc_block_bypass) begin
               demod_sample_o <= {sample_i[7], sample_i};
            end else begin
               avg_reg <= avg_reg + (($signed({sample_i, 8'h00}) - avg_reg) >>> `MFSC_DC_SHIFT);
               demod_sample_o <= {sample_i[7], sample_i} - {avg_reg[15], avg_reg[15:8]};
            end
         end
      end
   end

   // Biphase coding is suppressed in serial mode and with 4-FSK
   assign biphase_eff = cfg_reg.biphase_en && !serial_mode_i &&
                        (cfg_reg.modulation_select != `MFSC_MOD_4FSK);

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_chip_o       <= 1'b0;
         tx_chip_valid_o <= 1'b0;
         chip2_reg       <= 1'b0;
         chip2_val_reg   <= 1'b0;
      end else if (tx_bit_valid_i) begin
         tx_chip_o       <= tx_bit_i;
         tx_chip_valid_o <= 1'b1;
         chip2_reg       <= !tx_bit_i;
         chip2_val_reg   <= biphase_eff;
      end else begin
         tx_chip_o       <= chip2_reg;
         tx_chip_valid_o <= chip2_val_reg;
         chip2_val_reg   <= 1'b0;
      end
   end

   // Receive chips to bits
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_phase_reg <= 1'b0;
         rx_first_reg <= 1'b0;
      end else if (!biphase_eff) begin
         rx_phase_reg <= 1'b0;
      end else if (rx_chip_valid_i) begin
         rx_phase_reg <= !rx_phase_reg;
         rx_first_reg <= rx_chip_i;
      end
   end

   assign bit_valid = rx_chip_valid_i && (!biphase_eff || rx_phase_reg);
   assign bit_val   = biphase_eff ? rx_first_reg : rx_chip_i;

   // Sync word search
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_reg <= 32'h00000000;
         seen_reg  <= 6'h00;
      end else if (state_reg != MFSC_HUNT) begin
         seen_reg <= 6'h00;
      end else if (bit_valid) begin
         shift_reg <= {shift_reg[30:0], bit_val};
         if (seen_reg != `MFSC_LEN32) begin
            seen_reg <= seen_reg + 6'h01;
         end
      end
   end

   assign miss16 = ones32({16'h0000, shift_reg[15:0] ^ sync_word_i});
   assign miss32 = ones32(shift_reg ^ {sync_word_i, sync_word_i});

   always_comb begin
      case (cfg_reg.sync_mode[1:0])
         2'h0: qual_c = 1'b1;
         2'h1: qual_c = (seen_reg >= `MFSC_LEN16) && (miss16 <= `MFSC_MISS16_MAX);
         2'h2: qual_c = (seen_reg >= `MFSC_LEN16) && (miss16 == 6'h00);
         2'h3: qual_c = (seen_reg == `MFSC_LEN32) && (miss32 <= `MFSC_MISS32_MAX);
         default: qual_c = 1'b0;
      endcase
      if (cfg_reg.sync_mode[2] && !carrier_sense_i) begin
         qual_c = 1'b0;
      end
   end

   // Packet reception control
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg       <= MFSC_HUNT;
         pkt_start_o     <= 1'b0;
         rx_active_o     <= 1'b0;
         rx_data_o       <= 1'b0;
         rx_data_valid_o <= 1'b0;
      end else begin
         pkt_start_o     <= 1'b0;
         rx_data_valid_o <= 1'b0;
         case (state_reg)
            MFSC_HUNT: begin
               if (qual_c) begin
                  state_reg   <= MFSC_RECV;
                  pkt_start_o <= 1'b1;
                  rx_active_o <= 1'b1;
               end
            end
            MFSC_RECV: begin
               if (rx_done_i) begin
                  state_reg   <= MFSC_HUNT;
                  rx_active_o <= 1'b0;
               end else begin
                  rx_data_o       <= bit_val;
                  rx_data_valid_o <= bit_valid;
               end
            end
            default: begin
               state_reg   <= MFSC_HUNT;
               rx_active_o <= 1'b0;
            end
         endcase
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   AST_BYPASS_PASS: assert property (
      sample_valid_i && cfg_reg.dc_block_bypass |=> demod_valid_o &&
      demod_sample_o == {$past(sample_i[7]), $past(sample_i)})
      else $error("Bypassed sample altered");
   AST_MOD_RESERVED: assert property (
      wr_en_i && addr_i == `MFSC_CFG_ADDR && !mod_ok |=> $stable(cfg_reg.modulation_select))
      else $error("Reserved modulation code stored");
   AST_BIPHASE_PAIR: assert property (
      tx_bit_valid_i && biphase_eff |=> tx_chip_valid_o && tx_chip_o == $past(tx_bit_i)
      ##1 tx_chip_valid_o && ($past(tx_bit_valid_i) || tx_chip_o == !$past(tx_bit_i, 2)))
      else $error("Biphase chip pair broken");
   AST_NO_SYNC: assert property (
      state_reg == MFSC_HUNT && cfg_reg.sync_mode == 3'h0 |=> pkt_start_o && rx_active_o)
      else $error("No-sync mode did not start at once");
   AST_SHORT16: assert property (
      cfg_reg.sync_mode[1:0] != 2'h0 && seen_reg < `MFSC_LEN16 |-> !qual_c)
      else $error("Qualified before 16 bits");
   AST_MISS2_16: assert property (
      cfg_reg.sync_mode[1:0] == 2'h1 && miss16 == 6'h02 |-> !qual_c)
      else $error("15/16 accepted two errors");
   AST_EXACT16: assert property (
      cfg_reg.sync_mode[1:0] == 2'h2 && miss16 == 6'h01 |-> !qual_c)
      else $error("16/16 accepted one error");
   AST_MATCH32: assert property (
      cfg_reg.sync_mode == 3'h3 && seen_reg == `MFSC_LEN32 && miss32 == 6'h02 |-> qual_c)
      else $error("30/32 match rejected");
   AST_CARRIER_ONLY: assert property (
      cfg_reg.sync_mode == 3'h4 |-> qual_c == carrier_sense_i)
      else $error("Carrier-only mode wrong");
   AST_CS32: assert property (
      cfg_reg.sync_mode == 3'h7 && !carrier_sense_i |-> !qual_c)
      else $error("Mode 7 without carrier qualified");
   AST_HOLD_OFF: assert property (
      state_reg == MFSC_HUNT && !qual_c |=> !pkt_start_o && !rx_active_o && !rx_data_valid_o)
      else $error("Reception began unqualified");

endmodule

// ==== verif/mfsc_radio.sv ====
/*
 * Remote radio model: sends a chip stream MSB first, with idle gaps.
 * Assumes mclk_i from the bench; start_i is sampled on a rising edge.
 */
`timescale 1ns/10ps
module mfsc_radio (
   input  wire logic        mclk_i,
   input  wire logic        start_i,
   input  wire logic [31:0] word_i,
   input  wire logic [5:0]  nbits_i,
   input  wire logic [1:0]  gap_i,
   output logic             chip_o = 1'b0,
   output logic             chip_valid_o = 1'b0,
   output logic             busy_o = 1'b0
);
   int i;
   always begin
      @(posedge mclk_i);
      if (start_i) begin
         busy_o = 1'b1;
         for (i = nbits_i - 1; i >= 0; i--) begin
            @(negedge mclk_i);
            chip_o       = word_i[i];
            chip_valid_o = 1'b1;
            @(negedge mclk_i);
            chip_valid_o = 1'b0;
            chip_o       = ~word_i[i];
            repeat (gap_i) @(negedge mclk_i);
         end
         busy_o = 1'b0;
      end
   end
endmodule

// ==== verif/modem_format_sync_config_tb.sv ====
/*
 * Self-checking bench of the modem format and sync configuration block.
 * Assumes mfsc_top and the radio model; inputs change on falling edges.
 */
`timescale 1ns/10ps
module modem_format_sync_config_tb;
   import mfsc_pkg::*;
   logic        mclk_i = 1'b0, rst_i = 1'b1, wr_en_i = 1'b0, serial_mode_i = 1'b0;
   logic        sample_valid_i = 1'b0, tx_bit_i = 1'b0, tx_bit_valid_i = 1'b0;
   logic        carrier_sense_i = 1'b0, rx_done_i = 1'b0, rx_chip_i, rx_chip_valid_i;
   logic [5:0]  addr_i = 6'h00, rbits = 6'h10;
   logic [7:0]  wdata_i = 8'h00, rdata_o, v;
   logic signed [7:0] sample_i = 8'sh00;
   logic signed [8:0] demod_sample_o;
   logic [15:0] sync_word_i = 16'h0000, rxd;
   logic        demod_valid_o, tx_chip_o, tx_chip_valid_o, pkt_start_o, rx_active_o;
   logic        rx_data_o, rx_data_valid_o, rstart = 1'b0, rbusy;
   logic [31:0] rword = 32'h0, mask;
   logic [1:0]  rgap = 2'h1;
   mfsc_cfg_t   cfg_o;
   int          num_errors = 0, tests_run = 0, seed = 78, starts, datas, avg, e, k, i;
   int          md, er, cs, nb, q;
   int          tbl [14] = '{110, 120, 200, 210, 320, 330, 511, 500, 601, 721, 700, 0, 401, 400};
   logic [7:0]  txc [4] = '{8'h0a, 8'h0a, 8'h4a, 8'h02};
   logic        txs [4] = '{1'b0, 1'b1, 1'b0, 1'b0};

   always #4 mclk_i = ~mclk_i;

   mfsc_top i_dut (.mclk_i, .rst_i, .addr_i, .wr_en_i, .wdata_i, .rdata_o, .cfg_o, .serial_mode_i,
      .sample_i, .sample_valid_i, .demod_sample_o, .demod_valid_o, .tx_bit_i, .tx_bit_valid_i,
      .tx_chip_o, .tx_chip_valid_o, .rx_chip_i, .rx_chip_valid_i, .sync_word_i,
      .carrier_sense_i, .rx_done_i, .pkt_start_o, .rx_active_o, .rx_data_o, .rx_data_valid_o);
   mfsc_radio i_radio (.mclk_i, .start_i(rstart), .word_i(rword), .nbits_i(rbits), .gap_i(rgap),
      .chip_o(rx_chip_i), .chip_valid_o(rx_chip_valid_i), .busy_o(rbusy));

   always @(posedge mclk_i) begin
      if (pkt_start_o === 1'b1) starts++;
      if (rx_data_valid_o === 1'b1) begin
         datas++;
         rxd = {rxd[14:0], rx_data_o};
      end
   end

   task chk(input logic [31:0] g, input logic [31:0] x, input string m);
      tests_run++;
      if (g !== x) begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   task wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      addr_i  = a;
      wr_en_i = 1'b1;
      wdata_i = d;
      @(negedge mclk_i);
      wr_en_i = 1'b0;
   endtask

   task rd(input logic [5:0] a, output logic [7:0] d);
      @(negedge mclk_i);
      addr_i = a;
      @(negedge mclk_i);
      d = rdata_o;
   endtask

   task end_of_test;
      $display("errors %0d, comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge mclk_i);
      num_errors++;
      end_of_test;
   end

   initial begin
      repeat (16) @(negedge mclk_i);
      rst_i = 1'b0;
      rd(6'h12, v);
      chk(v, 8'h02, "reset value");
      wr(6'h13, 8'hff);
      rd(6'h13, v);
      chk({v, cfg_o}, 16'h0002, "unmapped address");
      for (k = 0; k < 8; k++) begin
         e = (k == 2 || k > 4) ? e : k;
         wr(6'h12, {1'b0, k[2:0], 4'h2});
         rd(6'h12, v);
         chk(v, {1'b0, e[2:0], 4'h2}, "modulation code");
      end
      $display("register test done");
      avg = 0;
      for (k = 0; k < 12; k++) begin
         if (k == 8) wr(6'h12, 8'h82); // Sets dc_block_bypass; later samples pass unfiltered
         @(negedge mclk_i);
         sample_i       = (k < 8) ? 8'sh64 : 8'($random(seed));
         sample_valid_i = 1'b1;
         @(negedge mclk_i);
         sample_valid_i = 1'b0;
         e   = 100 - (avg >>> 8);
         avg = avg + (((100 <<< 8) - avg) >>> 5);
         chk(demod_valid_o, 1'b1, "sample valid");
         if (k < 8) chk({23'h0, demod_sample_o}, e, "filtered sample");
         else chk({23'h0, demod_sample_o}, {23'h0, sample_i[7], sample_i}, "bypass");
      end
      $display("dc filter test done");
      for (k = 0; k < 4; k++) begin
         wr(6'h12, txc[k]);
         serial_mode_i = txs[k];
         @(negedge mclk_i);
         tx_bit_i       = 1'($random(seed));
         tx_bit_valid_i = 1'b1;
         @(negedge mclk_i);
         tx_bit_valid_i = 1'b0;
         chk({tx_chip_valid_o, tx_chip_o}, {1'b1, tx_bit_i}, "first chip");
         @(negedge mclk_i);
         chk(tx_chip_valid_o, k == 0, "second chip valid");
         if (k == 0) chk(tx_chip_o, !tx_bit_i, "second chip");
      end
      serial_mode_i = 1'b0;
      $display("biphase test done");
      sync_word_i = 16'($random(seed));
      for (k = 0; k < 14; k++) begin
         md = tbl[k] / 100;
         er = (tbl[k] / 10) % 10;
         cs = tbl[k] % 10;
         nb = (md % 4 == 3) ? 32 : 16;
         q  = (md % 4 == 0 || er <= ((md % 4 == 1) ? 1 : (md % 4 == 2) ? 0 : 2)) && (md < 4 || cs);
         mask = 32'h0;
         for (i = 0; i < er; i++) mask[2 * i + 1] = 1'b1;
         rst_i = 1'b1; // Clears bit history left by the previous case
         @(negedge mclk_i);
         rst_i = 1'b0;
         carrier_sense_i = cs[0];
         wr(6'h12, md[7:0]);
         @(negedge mclk_i);
         rx_done_i = 1'b1;
         @(negedge mclk_i);
         rx_done_i = 1'b0;
         repeat (4) @(negedge mclk_i);
         starts = 0;
         datas  = 0;
         rword  = {sync_word_i, sync_word_i} ^ mask;
         rbits  = nb[5:0];
         rgap   = 2'($random(seed));
         rstart = 1'b1;
         @(negedge mclk_i);
         rstart = 1'b0;
         for (i = 0; i < 300 && rbusy; i++) @(negedge mclk_i);
         repeat (4) @(negedge mclk_i);
         chk(starts, q && md % 4 != 0, "qualification");
         chk(datas, (q && md % 4 == 0) ? 16 : 0, "data count");
         chk(rx_active_o, q, "receiving state");
         if (q && md % 4 == 0) chk(rxd, rword[15:0], "received data");
      end
      $display("sync qualifier test done");
      end_of_test;
   end
endmodule
